// file: hdl/csc_pkg.sv
package csc_pkg;

   // register offsets (byte addresses on the plain register port)
   localparam logic [7:0] OFF_METHOD_TABLE  = 8'h00;
   localparam logic [7:0] OFF_DRIVER_EN     = 8'h02;
   localparam logic [7:0] OFF_COMMAND       = 8'h03;
   localparam logic [7:0] OFF_STATE         = 8'h04;
   localparam logic [7:0] OFF_STEP_CTRL     = 8'h05;
   localparam logic [7:0] OFF_CONT_WEIGHT   = 8'h07;
   localparam logic [7:0] OFF_CONT_STEPS    = 8'h08;
   localparam logic [7:0] OFF_FAST_WEIGHT   = 8'h09;
   localparam logic [7:0] OFF_DRIVER_ID     = 8'h0A;
   localparam logic [7:0] OFF_STATUS        = 8'h0B;
   localparam logic [7:0] OFF_OUTDOOR_THR   = 8'h14;

   // values after reset
   localparam logic [15:0] RST_METHOD_TABLE = 16'hF06B;
   localparam logic [7:0]  RST_DRIVER_EN    = 8'h0F;
   localparam logic [7:0]  RST_COMMAND      = 8'h00;
   localparam logic [1:0]  RST_STEP_CTRL    = 2'h0;
   localparam logic [7:0]  RST_CONT_WEIGHT  = 8'h08;
   localparam logic [7:0]  RST_CONT_STEPS   = 8'h02;
   localparam logic [7:0]  RST_FAST_WEIGHT  = 8'h20;
   localparam logic [7:0]  RST_OUTDOOR_THR  = 8'h0A;

   // field positions
   localparam int BIT_EXPOSURE_EN = 0;
   localparam int BIT_OUTDOOR_EN  = 5;
   localparam int BIT_STEP_MODE   = 0;
   localparam int BIT_STEP_NEXT   = 1;
   localparam int BIT_ST_BUSY     = 0;
   localparam int BIT_ST_SINGLE   = 1;

   // weight at which luma averaging is off
   localparam logic [7:0] AVG_OFF_WEIGHT = 8'h20;

   // highest defined command code
   localparam logic [7:0] CMD_MAX = 8'h06;

   // driver group identifiers
   localparam logic [7:0] ID_SEQUENCER   = 8'h01;
   localparam logic [7:0] ID_EXPOSURE    = 8'h02;
   localparam logic [7:0] ID_WHITE_BAL   = 8'h03;
   localparam logic [7:0] ID_FLICKER     = 8'h04;
   localparam logic [7:0] ID_MODE        = 8'h07;
   localparam logic [7:0] ID_COMPRESSION = 8'h09;
   localparam logic [7:0] ID_EXT_OFFSET  = 8'h10;

   // free-running step interval
   localparam int CLK_KHZ       = 25000;
   localparam int STEP_PERIOD_US = 4;
   localparam int STEP_CYCLES   = (CLK_KHZ * STEP_PERIOD_US) / 1000;
   localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES - 1);

   typedef enum logic [3:0] {
      ST_INIT, ST_CHG_PREVIEW, ST_ENTER_PREVIEW, ST_PREVIEW, ST_LEAVE_PREVIEW,
      ST_CHG_CAPTURE, ST_ENTER_CAPTURE, ST_CAPTURE, ST_LEAVE_CAPTURE, ST_STANDBY
   } csc_state_e;

   typedef enum logic [2:0] {
      CMD_RUN, CMD_PREVIEW, CMD_CAPTURE, CMD_STANDBY, CMD_LOCK, CMD_REFRESH,
      CMD_REFRESH_MODE
   } csc_cmd_e;

   typedef enum logic [1:0] {GOAL_NONE, GOAL_PREVIEW, GOAL_CAPTURE, GOAL_STANDBY} csc_goal_e;
   typedef enum logic [1:0] {ACT_NONE, ACT_LOCK, ACT_REFRESH, ACT_REFRESH_MODE} csc_act_e;

   typedef struct packed {
      logic [7:0] cont_weight;
      logic [7:0] cont_steps;
      logic [7:0] fast_weight;
      logic       cont_avg_off;
      logic       fast_avg_off;
   } csc_exp_s;

   typedef struct packed {
      logic lock;
      logic refresh;
      logic refresh_mode;
   } csc_pulse_s;

endpackage

// file: hdl/csc_step_tick.sv
`timescale 1ns/1ps
`default_nettype none

// one-cycle enable every STEP_CYCLES clocks for free-running steps
module csc_step_tick
   import csc_pkg::*;
(
   input  wire logic clk_i,   // system clock
   input  wire logic rst_i,   // async reset, high
   output logic      tick_o   // step enable pulse
);

   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic       tick_d;

   always_comb begin
      tick_d = (cnt_q == STEP_LAST);
      cnt_d  = tick_d ? 8'h00 : cnt_q + 8'h01;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q  <= 8'h00;
         tick_o <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         tick_o <= tick_d;
      end
   end

endmodule

`default_nettype wire

// file: hdl/csc_sequencer.sv
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// How it works
// [RL1] driver groups have numeric IDs; extensions add sixteen to the base ID
// [RL2] driver switch byte holds enables, bit 0 exposure driver, resets to 0x0F
// [RL3] switch bit 5 and exposure above outdoor threshold force outdoor white balance
// [RL4] command byte codes: run, preview, capture, standby, lock, refresh, refresh mode
// [RL5] a positive command is cleared, its program runs, then current state resumes
// [RL6] read-only state byte reports sequencer state 0..9, resets to preview (3)
// [RL7] step control bit 0 selects single-step operation, clear means free-running
// [RL8] writing 1 to step control bit 1 advances exactly one step
// [RL9] continuous averaging weight resets to 8; 32 turns averaging off
// [RL10] continuous step count resets to 2 and goes to the exposure driver
// [RL11] fast-mode averaging weight resets to 32, averaging off by default
// [RL12] commands above six are cleared and leave the state unchanged
module csc_sequencer
   import csc_pkg::*;
(
   input  wire logic        CLOCK_I,        // 25 MHz clock
   input  wire logic        RST_I,          // async reset, high
   input  wire logic [7:0]  ADDR_I,         // register address
   input  wire logic [15:0] WDATA_I,        // write data
   input  wire logic        WR_I,           // write strobe
   input  wire logic        RD_I,           // read strobe
   output logic      [15:0] RDATA_O,        // read data, cycle after RD_I
   input  wire logic [7:0]  EXPOSURE_VAL_I, // current exposure value
   output logic      [7:0]  DRIVER_EN_O,    // driver switch byte
   output logic             EXPOSURE_EN_O,  // exposure driver enable
   output logic             FORCE_OUTDOOR_O,// force outdoor white balance
   output csc_exp_s         EXPOSURE_O,     // exposure driver parameters
   output logic      [3:0]  STATE_O,        // current sequencer state
   output logic             BUSY_O,         // program in progress
   output csc_pulse_s       PULSE_O         // lock / refresh pulses
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   function automatic logic [7:0] ext_id(input logic [7:0] base);
      ext_id = base + ID_EXT_OFFSET; // [RL1]
   endfunction

   // one step from the current state toward the goal state
   function automatic csc_state_e toward(input csc_state_e s, input csc_goal_e g);
      toward = s;
      unique case (g)
         GOAL_PREVIEW: begin
            unique case (s)
               ST_CAPTURE:       toward = ST_LEAVE_CAPTURE;
               ST_CHG_PREVIEW:   toward = ST_ENTER_PREVIEW;
               ST_ENTER_PREVIEW: toward = ST_PREVIEW;
               ST_PREVIEW:       toward = ST_PREVIEW;
               default:          toward = ST_CHG_PREVIEW;
            endcase
         end
         GOAL_CAPTURE: begin
            unique case (s)
               ST_PREVIEW:       toward = ST_LEAVE_PREVIEW;
               ST_CHG_CAPTURE:   toward = ST_ENTER_CAPTURE;
               ST_ENTER_CAPTURE: toward = ST_CAPTURE;
               ST_CAPTURE:       toward = ST_CAPTURE;
               default:          toward = ST_CHG_CAPTURE;
            endcase
         end
         GOAL_STANDBY: begin
            unique case (s)
               ST_PREVIEW: toward = ST_LEAVE_PREVIEW;
               ST_CAPTURE: toward = ST_LEAVE_CAPTURE;
               default:    toward = ST_STANDBY;
            endcase
         end
         GOAL_NONE: toward = s;
      endcase
   endfunction

   function automatic csc_state_e goal_state(input csc_goal_e g);
      unique case (g)
         GOAL_CAPTURE: goal_state = ST_CAPTURE;
         GOAL_STANDBY: goal_state = ST_STANDBY;
         default:      goal_state = ST_PREVIEW;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // step enable

   logic tick;

   csc_step_tick u_tick (
      .clk_i  (CLOCK_I),
      .rst_i  (RST_I),
      .tick_o (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // software registers

   logic [7:0] drv_en_q, drv_en_d;
   logic [7:0] cmd_q, cmd_d;
   logic [1:0] step_q, step_d;
   logic [7:0] cont_w_q, cont_w_d;
   logic [7:0] cont_s_q, cont_s_d;
   logic [7:0] fast_w_q, fast_w_d;
   logic [7:0] thr_q, thr_d;
   logic       wr_en, wr_cmd, wr_step;
   logic       step_used;

   always_comb begin
      drv_en_d = drv_en_q;
      cont_w_d = cont_w_q;
      cont_s_d = cont_s_q;
      fast_w_d = fast_w_q;
      thr_d    = thr_q;
      step_d   = step_q;
      cmd_d    = cmd_q;
      wr_en    = WR_I;
      wr_cmd   = wr_en && hit(ADDR_I, OFF_COMMAND);
      wr_step  = wr_en && hit(ADDR_I, OFF_STEP_CTRL);
      if (wr_en && hit(ADDR_I, OFF_DRIVER_EN)) begin
         drv_en_d = WDATA_I[7:0]; // [RL2]
      end
      if (wr_en && hit(ADDR_I, OFF_CONT_WEIGHT)) begin
         cont_w_d = WDATA_I[7:0]; // [RL9]
      end
      if (wr_en && hit(ADDR_I, OFF_CONT_STEPS)) begin
         cont_s_d = WDATA_I[7:0]; // [RL10]
      end
      if (wr_en && hit(ADDR_I, OFF_FAST_WEIGHT)) begin
         fast_w_d = WDATA_I[7:0]; // [RL11]
      end
      if (wr_en && hit(ADDR_I, OFF_OUTDOOR_THR)) begin
         thr_d = WDATA_I[7:0];
      end
      // the advance request is consumed once seen; a new write wins
      if (step_used) begin
         step_d[BIT_STEP_NEXT] = 1'b0; // [RL8]
      end
      if (wr_step) begin
         step_d = WDATA_I[1:0]; // [RL7]
      end
      // any nonzero command byte is cleared next cycle; only codes up to six are taken
      if (cmd_q != 8'h00) begin
         cmd_d = 8'h00; // [RL5] [RL12]
      end
      if (wr_cmd) begin
         cmd_d = WDATA_I[7:0]; // [RL4]
      end
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         drv_en_q <= RST_DRIVER_EN; // [RL2]
         cmd_q    <= RST_COMMAND;   // [RL4]
         step_q   <= RST_STEP_CTRL; // [RL7]
         cont_w_q <= RST_CONT_WEIGHT; // [RL9]
         cont_s_q <= RST_CONT_STEPS;  // [RL10]
         fast_w_q <= RST_FAST_WEIGHT; // [RL11]
         thr_q    <= RST_OUTDOOR_THR;
      end else begin
         drv_en_q <= drv_en_d;
         cmd_q    <= cmd_d;
         step_q   <= step_d;
         cont_w_q <= cont_w_d;
         cont_s_q <= cont_s_d;
         fast_w_q <= fast_w_d;
         thr_q    <= thr_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program execution

   csc_state_e state_q, state_d;
   csc_goal_e  goal_q, goal_d;
   csc_act_e   act_q, act_d;
   csc_pulse_s pulse_d;
   logic       step_en;
   logic       single;

   always_comb begin
      state_d   = state_q;
      goal_d    = goal_q;
      act_d     = act_q;
      pulse_d   = '0;
      single    = step_q[BIT_STEP_MODE];
      // single-step waits for the advance bit, otherwise the divider paces
      step_en   = single ? step_q[BIT_STEP_NEXT] : tick; // [RL7] [RL8]
      step_used = step_q[BIT_STEP_NEXT];
      if (step_en) begin
         if (goal_q != GOAL_NONE) begin
            state_d = toward(state_q, goal_q); // [RL5]
            if (state_d == goal_state(goal_q)) begin
               goal_d = GOAL_NONE;
            end
         end else if (act_q != ACT_NONE) begin
            pulse_d.lock         = (act_q == ACT_LOCK);
            pulse_d.refresh      = (act_q == ACT_REFRESH);
            pulse_d.refresh_mode = (act_q == ACT_REFRESH_MODE);
            act_d                = ACT_NONE;
         end
      end
      // a command taken now replaces any unfinished program
      if ((cmd_q != 8'h00) && (cmd_q <= CMD_MAX)) begin // [RL12]
         unique case (csc_cmd_e'(cmd_q[2:0])) // [RL4]
            CMD_PREVIEW:      begin goal_d = GOAL_PREVIEW; act_d = ACT_NONE; end
            CMD_CAPTURE:      begin goal_d = GOAL_CAPTURE; act_d = ACT_NONE; end
            CMD_STANDBY:      begin goal_d = GOAL_STANDBY; act_d = ACT_NONE; end
            CMD_LOCK:         begin goal_d = GOAL_NONE; act_d = ACT_LOCK; end
            CMD_REFRESH:      begin goal_d = GOAL_NONE; act_d = ACT_REFRESH; end
            CMD_REFRESH_MODE: begin goal_d = GOAL_NONE; act_d = ACT_REFRESH_MODE; end
            default:          begin goal_d = goal_q; act_d = act_q; end
         endcase
      end
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         state_q <= ST_PREVIEW; // [RL6]
         goal_q  <= GOAL_NONE;
         act_q   <= ACT_NONE;
         PULSE_O <= '0;
      end else begin
         state_q <= state_d;
         goal_q  <= goal_d;
         act_q   <= act_d;
         PULSE_O <= pulse_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs to the drivers

   logic     outdoor_d;
   csc_exp_s exp_d;

   always_comb begin
      outdoor_d = drv_en_q[BIT_OUTDOOR_EN] && (EXPOSURE_VAL_I > thr_q); // [RL3]
      exp_d.cont_weight  = cont_w_q;
      exp_d.cont_steps   = cont_s_q; // [RL10]
      exp_d.fast_weight  = fast_w_q;
      // weights of 32 or more use only the current luma
      exp_d.cont_avg_off = (cont_w_q >= AVG_OFF_WEIGHT); // [RL9]
      exp_d.fast_avg_off = (fast_w_q >= AVG_OFF_WEIGHT); // [RL11]
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         FORCE_OUTDOOR_O <= 1'b0;
         EXPOSURE_O      <= '0;
      end else begin
         FORCE_OUTDOOR_O <= outdoor_d;
         EXPOSURE_O      <= exp_d;
      end
   end

   assign DRIVER_EN_O   = drv_en_q;
   assign EXPOSURE_EN_O = drv_en_q[BIT_EXPOSURE_EN]; // [RL2]
   assign STATE_O       = state_q;
   assign BUSY_O        = (goal_q != GOAL_NONE) || (act_q != ACT_NONE) || (cmd_q != 8'h00);

   ////////////////////////////////////////////////////////////////////////////
   // read path

   logic [15:0] rdata_d;
   logic [15:0] status;

   always_comb begin
      status                = '0;
      status[BIT_ST_BUSY]   = BUSY_O;
      status[BIT_ST_SINGLE] = single;
      rdata_d               = RDATA_O;
      if (RD_I) begin
         unique case (ADDR_I)
            OFF_METHOD_TABLE: rdata_d = RST_METHOD_TABLE;
            OFF_DRIVER_EN:    rdata_d = {8'h00, drv_en_q};
            OFF_COMMAND:      rdata_d = {8'h00, cmd_q};
            OFF_STATE:        rdata_d = {12'h000, state_q}; // [RL6]
            OFF_STEP_CTRL:    rdata_d = {14'h0000, step_q};
            OFF_CONT_WEIGHT:  rdata_d = {8'h00, cont_w_q};
            OFF_CONT_STEPS:   rdata_d = {8'h00, cont_s_q};
            OFF_FAST_WEIGHT:  rdata_d = {8'h00, fast_w_q};
            OFF_DRIVER_ID:    rdata_d = {ext_id(ID_SEQUENCER), ID_SEQUENCER}; // [RL1]
            OFF_STATUS:       rdata_d = status;
            OFF_OUTDOOR_THR:  rdata_d = {8'h00, thr_q};
            default:          rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge CLOCK_I or posedge RST_I) begin
      if (RST_I) begin
         RDATA_O <= 16'h0000;
      end else begin
         RDATA_O <= rdata_d;
      end
   end

endmodule

`default_nettype wire

// file: verification/csc_props.sv
`timescale 1ns/1ps
`default_nettype none

module csc_props
   import csc_pkg::*;
(
   input wire logic        CLOCK_I,         // clock
   input wire logic        RST_I,           // async reset, high
   input wire logic [7:0]  ADDR_I,          // register address
   input wire logic [15:0] WDATA_I,         // write data
   input wire logic        WR_I,            // write strobe
   input wire logic        RD_I,            // read strobe
   input wire logic [15:0] RDATA_O,         // read data
   input wire logic [7:0]  EXPOSURE_VAL_I,  // exposure value
   input wire logic [7:0]  DRIVER_EN_O,     // switch byte
   input wire logic        EXPOSURE_EN_O,   // exposure enable
   input wire logic        FORCE_OUTDOOR_O, // outdoor force
   input wire csc_exp_s    EXPOSURE_O,      // exposure parameters
   input wire logic [3:0]  STATE_O,         // state code
   input wire logic        BUSY_O,          // program busy
   input wire csc_pulse_s  PULSE_O          // action pulses
);
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (RST_I);

   property p_en_bit; EXPOSURE_EN_O == DRIVER_EN_O[BIT_EXPOSURE_EN]; endproperty
   a_en_bit: assert property (p_en_bit) else $error("exposure enable off switch");
   property p_drv_wr; WR_I && ADDR_I == OFF_DRIVER_EN |=> DRIVER_EN_O == $past(WDATA_I[7:0]);
   endproperty
   a_drv_wr: assert property (p_drv_wr) else $error("switch write lost");
   // a zero exposure value can never exceed any threshold
   property p_outdoor; FORCE_OUTDOOR_O |->
      $past(DRIVER_EN_O[BIT_OUTDOOR_EN]) && $past(EXPOSURE_VAL_I) != 8'h00; endproperty
   a_outdoor: assert property (p_outdoor) else $error("outdoor forced wrongly");
   property p_busy; WR_I && ADDR_I == OFF_COMMAND && WDATA_I[7:0] != 8'h00 |=> BUSY_O;
   endproperty
   a_busy: assert property (p_busy) else $error("command not pending");
   property p_state_rng; STATE_O <= 4'h9; endproperty
   a_state_rng: assert property (p_state_rng) else $error("state code out of range");
   property p_state_move; STATE_O != $past(STATE_O) |-> $past(BUSY_O); endproperty
   a_state_move: assert property (p_state_move) else $error("state moved while idle");
   property p_pulse; PULSE_O != 3'h0 |-> $onehot(PULSE_O) ##1 PULSE_O == 3'h0; endproperty
   a_pulse: assert property (p_pulse) else $error("action pulse malformed");
   property p_rd_id; RD_I && ADDR_I == OFF_DRIVER_ID |=>
      RDATA_O == {ID_SEQUENCER + ID_EXT_OFFSET, ID_SEQUENCER}; endproperty
   a_rd_id: assert property (p_rd_id) else $error("driver id wrong");
   property p_rd_state; RD_I && ADDR_I == OFF_STATE |=> RDATA_O == {12'h000, $past(STATE_O)};
   endproperty
   a_rd_state: assert property (p_rd_state) else $error("state readback wrong");
   property p_avg; EXPOSURE_O.cont_avg_off == (EXPOSURE_O.cont_weight >= AVG_OFF_WEIGHT) &&
      EXPOSURE_O.fast_avg_off == (EXPOSURE_O.fast_weight >= AVG_OFF_WEIGHT); endproperty
   a_avg: assert property (p_avg) else $error("averaging flag wrong");
   property p_steps; WR_I && ADDR_I == OFF_CONT_STEPS |=>
      ##1 EXPOSURE_O.cont_steps == $past(WDATA_I[7:0], 2); endproperty
   a_steps: assert property (p_steps) else $error("step count not passed on");
endmodule

bind csc_sequencer csc_props i_props (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
   .EXPOSURE_VAL_I(EXPOSURE_VAL_I), .DRIVER_EN_O(DRIVER_EN_O), .EXPOSURE_EN_O(EXPOSURE_EN_O),
   .FORCE_OUTDOOR_O(FORCE_OUTDOOR_O), .EXPOSURE_O(EXPOSURE_O), .STATE_O(STATE_O),
   .BUSY_O(BUSY_O), .PULSE_O(PULSE_O));

`default_nettype wire

// file: verification/camera_sequencer_control_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
   $display("BAD %s exp %0h got %0h", n, e, g); end end

module camera_sequencer_control_test;
   import csc_pkg::*;
   logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
   logic [7:0]  addr = 8'h00, ev = 8'h00, drv_en, ra_m, w, t;
   logic [15:0] wdata = 16'h0000, rdata, ex_m, r;
   logic        exp_en, force_o, busy;
   logic [3:0]  state;
   csc_exp_s    expo;
   csc_pulse_s  pulse;
   int          failures = 0, tests_run = 0, i, n_pulse[3] = '{0, 0, 0};
   logic [7:0]  adr_q[$];
   logic [15:0] exp_q[$];
   logic [7:0]  ra[11] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A,
                           8'h14, 8'h06};
   logic [15:0] rv[11] = '{16'hF06B, 16'h000F, 16'h0000, 16'h0003, 16'h0000, 16'h0008,
                           16'h0002, 16'h0020, 16'h1101, 16'h000A, 16'h0000};
   logic [15:0] walk[8] = '{16'h0004, 16'h0005, 16'h0006, 16'h0007, 16'h0008, 16'h0001,
                            16'h0002, 16'h0003};

   csc_sequencer i_dut (.CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .EXPOSURE_VAL_I(ev), .DRIVER_EN_O(drv_en),
      .EXPOSURE_EN_O(exp_en), .FORCE_OUTDOOR_O(force_o), .EXPOSURE_O(expo),
      .STATE_O(state), .BUSY_O(busy), .PULSE_O(pulse));

   initial forever #20 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      if (rd_seen) begin
         ra_m = adr_q.pop_front();
         ex_m = exp_q.pop_front();
         `CHK($sformatf("reg %h", ra_m), ex_m, rdata)
      end
      rd_seen <= rd;
      n_pulse[0] += int'(pulse.lock);
      n_pulse[1] += int'(pulse.refresh);
      n_pulse[2] += int'(pulse.refresh_mode);
   end

   ////////////////////////////////////////////////////////////////////////////////
   task wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task rd_reg(input logic [7:0] a, input logic [15:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      adr_q.push_back(a);
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask

   task step;
      wr_reg(OFF_STEP_CTRL, 16'h0003);
   endtask

   task conclude;
      $display("counts: %0d checks, %0d mismatches", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task wait_idle;
      int k;
      for (k = 0; k < 1000 && busy !== 1'b0; k++) @(posedge clk);
      if (busy !== 1'b0) begin
         failures++;
         $display("BAD busy exp 0 got %b", busy);
         conclude();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(74057));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 11; i++) rd_reg(ra[i], rv[i]);
      `CHK("exposure", csc_exp_s'{8'h08, 8'h02, 8'h20, 1'b0, 1'b1}, expo)
      wr_reg(OFF_STATE, 16'h0005);
      wr_reg(OFF_METHOD_TABLE, 16'h1234);
      rd_reg(OFF_STATE, 16'h0003);
      rd_reg(OFF_METHOD_TABLE, 16'hF06B);
      $display("done: reset values and read-only places");

      // weights straddle the averaging-off boundary, thresholds straddle the exposure
      for (i = 0; i < 6; i++) begin
         r = 16'($urandom) | (i < 4 ? 16'h0020 : 16'h0000);
         w = (i == 0) ? 8'h20 : (i == 1) ? 8'h1F : 8'($urandom) | 8'h01;
         t = w - 8'(i % 2);
         ev <= w;
         wr_reg(OFF_DRIVER_EN, r);
         wr_reg(OFF_OUTDOOR_THR, {8'h00, t});
         wr_reg(OFF_CONT_WEIGHT, {8'h00, w});
         wr_reg(OFF_CONT_STEPS, {8'h00, t});
         wr_reg(OFF_FAST_WEIGHT, {8'h00, r[15:8]});
         rd_reg(OFF_DRIVER_EN, {8'h00, r[7:0]});
         rd_reg(OFF_CONT_WEIGHT, {8'h00, w});
         `CHK("drv_en", r[7:0], drv_en)
         `CHK("exp_en", r[0], exp_en)
         `CHK("outdoor", r[5] && (w > t), force_o)
         `CHK("cont_off", w >= 8'h20, expo.cont_avg_off)
         `CHK("steps", t, expo.cont_steps)
         `CHK("weights", ({w, r[15:8]}), ({expo.cont_weight, expo.fast_weight}))
         `CHK("fast_off", r[15:8] >= 8'h20, expo.fast_avg_off)
      end
      $display("done: switches and exposure parameters");

      wr_reg(OFF_STEP_CTRL, 16'h0001);
      wr_reg(OFF_COMMAND, 16'h0002);
      rd_reg(OFF_COMMAND, 16'h0000);
      rd_reg(OFF_STATE, 16'h0003);
      `CHK("busy", 1'b1, busy)
      rd_reg(OFF_STATUS, 16'h0003);
      for (i = 0; i < 8; i++) begin
         if (i == 4) begin
            wr_reg(OFF_COMMAND, 16'h0007);
            wr_reg(OFF_COMMAND, 16'h0000);
            step();
            rd_reg(OFF_STATE, 16'h0007);
            rd_reg(OFF_COMMAND, 16'h0000);
            `CHK("busy", 1'b0, busy)
            wr_reg(OFF_COMMAND, 16'h0001);
         end
         step();
         rd_reg(OFF_STATE, walk[i]);
         `CHK("state", walk[i][3:0], state)
      end
      rd_reg(OFF_STEP_CTRL, 16'h0001);
      for (i = 0; i < 3; i++) begin
         wr_reg(OFF_COMMAND, 16'(4 + i));
         step();
         repeat (3) @(posedge clk);
         `CHK("pulses", 1, n_pulse[i])
      end
      rd_reg(OFF_STATE, 16'h0003);
      $display("done: single-step program walk");

      wr_reg(OFF_STEP_CTRL, 16'h0000);
      wr_reg(OFF_COMMAND, 16'h0003);
      wait_idle();
      rd_reg(OFF_STATE, 16'h0009);
      repeat (3) @(posedge clk);
      $display("done: free-running standby");
      conclude();
   end
endmodule

`default_nettype wire
